// ==== fpt_chk.sv ====
/* Port checker for the parameter table store.
   Assumes it is bound onto fpt_param_table and sees its ports only. */
`default_nettype none
module fpt_chk (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata
);
    logic view_q;
    logic wv;
    // Track byte view, since word checks only hold in word view
    always_ff @(posedge i_clk) begin
        if (i_reset)
            view_q <= 1'b0;
        else if (i_wr && i_addr[7:2] == 6'h20)
            view_q <= i_wdata[0];
    end
    assign wv = i_rd && !view_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_sig_word:
        assert property (wv && i_addr[7:2] == 6'h00 |=> o_rdata == 32'h5044_4653)
        else $error("signature word wrong");
    a_rev_word:
        assert property (wv && i_addr[7:2] == 6'h01 |=> o_rdata == 32'hFF00_0106)
        else $error("revision word wrong");
    a_hdr_word:
        assert property (wv && i_addr[7:2] == 6'h02 |=> o_rdata == 32'h1001_0600)
        else $error("header word wrong");
    a_ptr_word:
        assert property (wv && i_addr[7:2] == 6'h03 |=> o_rdata == 32'hFF00_0030)
        else $error("pointer word wrong");
    a_caps_word:
        assert property (wv && i_addr[7:2] == 6'h0C |=> o_rdata == 32'hFFF9_20E5)
        else $error("capability word wrong");
    a_quad_read:
        assert property (wv && i_addr[7:2] == 6'h0E |=> o_rdata == 32'h6B08_EB44)
        else $error("quad read word wrong");
    a_dual_read:
        assert property (wv && i_addr[7:2] == 6'h0F |=> o_rdata == 32'hBB80_3B08)
        else $error("dual read word wrong");
    a_gap_ones:
        assert property (wv && i_addr[7:2] inside {[6'h04:6'h0B]} |=> o_rdata == 32'hFFFF_FFFF)
        else $error("reserved word not ones");
    a_byte_upper:
        assert property (i_rd && view_q && i_addr < 8'h40 |=> o_rdata[31:8] == 24'h00_0000)
        else $error("byte view upper bits set");
    a_unmapped_ones:
        assert property (i_rd && (i_addr[7:6] == 2'b01 || i_addr >= 8'h88)
            |=> o_rdata == 32'hFFFF_FFFF)
        else $error("unmapped read not ones");
    a_idle_zero:
        assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    c_sig: cover property (wv && i_addr == 8'h00);
    c_status: cover property (i_rd && i_addr[7:2] == 6'h21);
    c_view: cover property (i_rd && view_q);
    c_wr_tab: cover property (i_wr && i_addr < 8'h40);
endmodule
bind fpt_param_table fpt_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
`default_nettype wire

// ==== fpt_host_model.sv ====
/* Host side model: issues register reads and writes to the table.
   Assumes one clock; read data are taken in the cycle after the strobe. */
`default_nettype none
module fpt_host_model (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // Read: data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
    // Discovery follows the mandatory header's pointer and never looks for
    // optional headers, so a table without them still parses
    task automatic find_table(output logic [7:0] base);
        logic [31:0] w;
        rd(8'h0C, w);
        base = w[7:0];
    endtask
endmodule
`default_nettype wire

// ==== fpt_param_table.sv ====
/*
 * Read-only parameter table of a serial flash, reached over a plain
 * register port. Byte addresses 00h..3Fh hold the signature header, the
 * parameter header and the first four doublewords of the basic table.
 * A small control and status pair sits above the table.
 * Assumes a register master on i_clk: one-cycle strobes, never both at
 * once, read data taken in the cycle after the read strobe.
 */
// Decided for this implementation: the address-and-strobe port and the address map.
`default_nettype none

module fpt_param_table #(
    parameter logic [31:0] DENSITY_WORD = 32'hFFFF_FFFF
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);

    logic byte_view_q;
    logic unmapped_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] table_word;
    logic [15:0] refuse_count;
    logic in_table;
    logic hit_ctrl;
    logic hit_status;
    logic refused_wr;
    logic status_clear;

    // Address decode; the low two bits only matter in byte view
    assign in_table = (i_addr <= fpt_pkg::TABLE_LAST_ADDR);
    assign hit_ctrl = ({i_addr[7:2], 2'b00} == fpt_pkg::CTRL_ADDR);
    assign hit_status = ({i_addr[7:2], 2'b00} == fpt_pkg::STATUS_ADDR);

    // Any write that is not to the control pair is refused and counted
    assign refused_wr = i_wr && !hit_ctrl && !hit_status;
    assign status_clear = i_wr && hit_status;

    fpt_table_rom u_rom (
        .i_word_idx(i_addr[5:2]),
        .i_density_word(DENSITY_WORD),
        .o_word(table_word)
    );

    fpt_refuse_counter u_refuse (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_hit(refused_wr),
        .i_clear(status_clear),
        .o_count(refuse_count)
    );

    // Byte view lets a host walk the database one byte per read
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            byte_view_q <= fpt_pkg::CTRL_BYTE_VIEW_RESET;
        end else if (i_wr && hit_ctrl) begin
            byte_view_q <= i_wdata[fpt_pkg::CTRL_BYTE_VIEW_BIT];
        end
    end

    // Records whether the latest read fell outside the map
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            unmapped_q <= 1'b0;
        end else if (i_rd) begin
            unmapped_q <= !in_table && !hit_ctrl && !hit_status;
        end
    end

    // Read data; doublewords are little-endian so byte n is lane n
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_rd) begin
            if (in_table) begin
                if (byte_view_q) begin
                    rdata_d = {24'h00_0000, table_word[{i_addr[1:0], 3'b000} +: 8]};
                end else begin
                    rdata_d = table_word;
                end
            end else if (hit_ctrl) begin
                rdata_d = {31'h0000_0000, byte_view_q};
            end else if (hit_status) begin
                rdata_d = {15'h0000, unmapped_q, refuse_count};
            end else begin
                rdata_d = fpt_pkg::ALL_ONES_WORD;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== fpt_param_table_tb.sv ====
/* Self-checking bench for the parameter table store.
   Assumes the host model drives the register port. */
`default_nettype none
module fpt_param_table_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DENS = 32'h01FF_FFFF;
    logic i_clk, i_reset, wr, rd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got, exp_w;
    logic [7:0] base;
    int bad_count = 0;
    int tests_run = 0;
    fpt_param_table #(.DENSITY_WORD(DENS)) u_dut (.i_clk(i_clk), .i_reset(i_reset),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
    fpt_host_model u_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Expected database words, little-endian bytes
    function automatic logic [31:0] ew(input logic [7:0] a);
        case (a[5:2])
            4'h0: return 32'h5044_4653;
            4'h1: return 32'hFF00_0106;
            4'h2: return 32'h1001_0600;
            4'h3: return 32'hFF00_0030;
            4'hC: return 32'hFFF9_20E5;
            4'hD: return DENS;
            4'hE: return 32'h6B08_EB44;
            4'hF: return 32'hBB80_3B08;
            default: return 32'hFFFF_FFFF;
        endcase
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #50us;
        bad_count++;
        complete_run();
    end
    initial begin
        i_reset = 1'b1;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        // Word view over the whole table region
        for (int a = 0; a < 64; a += 4) begin
            u_host.rd(8'(a), got);
            chk(got, ew(8'(a)));
        end
        $display("word walk done");
        // Host finds the basic table through the header pointer
        u_host.find_table(base);
        chk({24'h00_0000, base}, 32'h0000_0030);
        u_host.rd(base, got);
        chk(got, 32'hFFF9_20E5);
        // Writes into the table are refused and counted
        u_host.wr(8'h00, 32'h0000_0000);
        u_host.wr(8'h30, 32'h0000_0000);
        u_host.rd(8'h00, got);
        chk(got, 32'h5044_4653);
        u_host.rd(8'h30, got);
        chk(got, 32'hFFF9_20E5);
        u_host.rd(8'h84, got);
        chk(got[15:0], 16'h0002);
        u_host.wr(8'h84, 32'h0000_0000);
        u_host.rd(8'h84, got);
        chk(got[15:0], 16'h0000);
        $display("refusal done");
        // Byte view over header and basic table bytes
        u_host.wr(8'h80, 32'h0000_0001);
        for (int a = 0; a < 64; a++) begin
            u_host.rd(8'(a), got);
            exp_w = ew(8'(a));
            chk(got, {24'h00_0000, exp_w[8*(a%4)+:8]});
        end
        $display("byte walk done");
        // Unmapped reads, status flag and count, then a reset in mid-run
        u_host.rd(8'h90, got);
        chk(got, 32'hFFFF_FFFF);
        u_host.wr(8'h20, 32'h0000_0000);
        u_host.rd(8'h84, got);
        chk(got, 32'h0001_0001);
        u_host.rd(8'h40, got);
        chk(got, 32'hFFFF_FFFF);
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        u_host.rd(8'h84, got);
        chk(got, 32'h0000_0000);
        u_host.rd(8'h80, got);
        chk(got, 32'h0000_0000);
        u_host.rd(8'h00, got);
        chk(got, 32'h5044_4653);
        $display("reset done");
        complete_run();
    end
endmodule
`default_nettype wire

// ==== fpt_pkg.sv ====
/*
 * Constants for the flash parameter table store: the byte map of the
 * signature header, the parameter header and the first four doublewords
 * of the basic parameter table, plus the small control block around them.
 * Assumes nothing of its surroundings; it is pure definitions.
 */
`default_nettype none

package fpt_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte addresses of the map
    localparam logic [7:0] TABLE_LAST_ADDR = 8'h3F;
    localparam logic [7:0] CTRL_ADDR = 8'h80;
    localparam logic [7:0] STATUS_ADDR = 8'h84;

    // Control and status field positions
    localparam int CTRL_BYTE_VIEW_BIT = 0;
    localparam int STATUS_COUNT_W = 16;
    localparam int STATUS_UNMAPPED_BIT = 16;

    // Values after reset, and the ceiling of the refusal count
    localparam logic CTRL_BYTE_VIEW_RESET = 1'b0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Unmapped addresses and table gaps read as ones, like erased flash; unused control and status bits read as zero
    localparam logic [31:0] ALL_ONES_WORD = 32'hFFFF_FFFF;

    // Signature, lowest address first
    localparam logic [7:0] SIG_B0 = 8'h53;
    localparam logic [7:0] SIG_B1 = 8'h46;
    localparam logic [7:0] SIG_B2 = 8'h44;
    localparam logic [7:0] SIG_B3 = 8'h50;

    // Database revision and header count
    localparam logic [7:0] REV_MINOR = 8'h06;
    localparam logic [7:0] REV_MAJOR = 8'h01;
    localparam logic [7:0] HEADER_COUNT_FIELD = 8'h00;
    localparam logic [7:0] UNUSED_BYTE = 8'hFF;

    // Mandatory parameter header
    localparam logic [15:0] PARAM_ID = 16'hFF00;
    localparam logic [7:0] TABLE_LEN_DW = 8'h10;
    localparam logic [23:0] TABLE_POINTER_FIELD = 24'h00_0030;

    // Table byte 30h fields, and the 4K erase opcode in byte 31h
    localparam logic [1:0] ERASE_SIZE_CODE = 2'b01;
    localparam logic WRITE_GRAN = 1'b1;
    localparam logic VOLATILE_BP = 1'b0;
    localparam logic WREN_SELECT = 1'b0;
    localparam logic [7:0] ERASE_4K_OPCODE = 8'h20;

    // Table byte 32h fields
    localparam logic READ_112_OK = 1'b1;
    localparam logic [1:0] ADDR_BYTES_CODE = 2'b00;
    localparam logic DTR_OK = 1'b1;
    localparam logic READ_122_OK = 1'b1;
    localparam logic READ_144_OK = 1'b1;
    localparam logic READ_114_OK = 1'b1;

    // Multi-I/O read wait, mode and opcode values
    localparam logic [4:0] WAIT_144 = 5'b00100;
    localparam logic [2:0] MODE_144 = 3'b010;
    localparam logic [7:0] OPC_144 = 8'hEB;
    localparam logic [4:0] WAIT_114 = 5'b01000;
    localparam logic [2:0] MODE_114 = 3'b000;
    localparam logic [7:0] OPC_114 = 8'h6B;
    localparam logic [4:0] WAIT_112 = 5'b01000;
    localparam logic [2:0] MODE_112 = 3'b000;
    localparam logic [7:0] OPC_112 = 8'h3B;
    localparam logic [4:0] WAIT_122 = 5'b00000;
    localparam logic [2:0] MODE_122 = 3'b100;
    localparam logic [7:0] OPC_122 = 8'hBB;

    // Assembled doublewords, least significant byte at lowest address
    localparam logic [31:0] WORD_00 = {SIG_B3, SIG_B2, SIG_B1, SIG_B0};
    localparam logic [31:0] WORD_04 = {UNUSED_BYTE, HEADER_COUNT_FIELD, REV_MAJOR, REV_MINOR};
    localparam logic [31:0] WORD_08 = {TABLE_LEN_DW, REV_MAJOR, REV_MINOR, PARAM_ID[7:0]};
    localparam logic [31:0] WORD_0C = {PARAM_ID[15:8], TABLE_POINTER_FIELD};
    localparam logic [31:0] WORD_30 = {8'hFF, 1'b1, READ_114_OK, READ_144_OK, READ_122_OK,
        DTR_OK, ADDR_BYTES_CODE, READ_112_OK, ERASE_4K_OPCODE, 3'b111, WREN_SELECT,
        VOLATILE_BP, WRITE_GRAN, ERASE_SIZE_CODE};
    localparam logic [31:0] WORD_38 = {OPC_114, MODE_114, WAIT_114, OPC_144, MODE_144, WAIT_144};
    localparam logic [31:0] WORD_3C = {OPC_122, MODE_122, WAIT_122, OPC_112, MODE_112, WAIT_112};

    // Doubleword indices within the table region
    localparam logic [3:0] IDX_00 = 4'h0;
    localparam logic [3:0] IDX_04 = 4'h1;
    localparam logic [3:0] IDX_08 = 4'h2;
    localparam logic [3:0] IDX_0C = 4'h3;
    localparam logic [3:0] IDX_30 = 4'hC;
    localparam logic [3:0] IDX_34 = 4'hD;
    localparam logic [3:0] IDX_38 = 4'hE;
    localparam logic [3:0] IDX_3C = 4'hF;

endpackage

`default_nettype wire

// ==== fpt_refuse_counter.sv ====
/*
 * Saturating counter of write attempts that were refused.
 * Assumes a single clock and a synchronous active-high reset.
 */
`default_nettype none

module fpt_refuse_counter (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_hit,
    input wire logic i_clear,
    output logic [15:0] o_count
);

    logic [15:0] count_q;

    // A hit in the same cycle as a clear still counts, so no event is lost
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_q <= fpt_pkg::COUNT_RESET;
        end else if (i_clear) begin
            count_q <= i_hit ? 16'h0001 : fpt_pkg::COUNT_RESET;
        end else if (i_hit && count_q != fpt_pkg::COUNT_MAX) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign o_count = count_q;

endmodule

`default_nettype wire

// ==== fpt_table_rom.sv ====
/*
 * Fixed lookup of one doubleword of the parameter database by index.
 * Purely combinational; the caller registers the result. Assumes the
 * index already lies inside the table region.
 */
`default_nettype none

module fpt_table_rom (
    input wire logic [3:0] i_word_idx,
    input wire logic [31:0] i_density_word,
    output logic [31:0] o_word
);

    // Gaps between the header and the table read as ones
    always_comb begin
        case (i_word_idx)
            fpt_pkg::IDX_00: o_word = fpt_pkg::WORD_00;
            fpt_pkg::IDX_04: o_word = fpt_pkg::WORD_04;
            fpt_pkg::IDX_08: o_word = fpt_pkg::WORD_08;
            fpt_pkg::IDX_0C: o_word = fpt_pkg::WORD_0C;
            fpt_pkg::IDX_30: o_word = fpt_pkg::WORD_30;
            fpt_pkg::IDX_34: o_word = i_density_word;
            fpt_pkg::IDX_38: o_word = fpt_pkg::WORD_38;
            fpt_pkg::IDX_3C: o_word = fpt_pkg::WORD_3C;
            default: o_word = fpt_pkg::ALL_ONES_WORD;
        endcase
    end

endmodule

`default_nettype wire
